// File: rtl/lim_top.sv
// local interrupt multiplexor: two local groups, routed inputs, timer ack
`timescale 1ns/1ps
module lim_top (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // register port, synchronous to sys_clk
    input  wire logic        reg_sel,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // group-zero sources, active high, asynchronous
    input  wire logic        graphics_irq,
    input  wire logic        parallel_irq,
    input  wire logic        mem_dma_done_irq,
    input  wire logic        ethernet_irq,
    input  wire logic        scsi1_irq,
    input  wire logic        scsi0_irq,
    input  wire logic        fifo_full_irq,
    // group-one sources
    input  wire logic        vert_retrace_irq,
    input  wire logic        video_vsync_irq,
    input  wire logic        ac_fail_irq,
    input  wire logic        periph_dma_done_irq,
    input  wire logic [1:0]  general_purpose_irq_lines_n,
    input  wire logic        power_button_irq_n,
    input  wire logic        volume_up_irq_n,
    input  wire logic        volume_down_irq_n,
    // routed inputs, polarity set by software
    input  wire logic [7:0]  routed_in,
    input  wire logic        serial_irq_n,
    input  wire logic        kbd_mouse_irq_n,
    // bus error sources, active high
    input  wire logic        periph_bus_err,
    input  wire logic        mem_bus_err,
    input  wire logic        eisa_err,
    // timer events, one-cycle pulses from same-clock timer logic
    input  wire logic [1:0]  timer_evt,
    // outputs toward the processor
    output logic             group0_irq,
    output logic             group1_irq,
    output logic      [1:0]  timer_irq
);

    localparam int SW = 27;  // number of synchronised pins

    // software-visible control registers
    logic [7:0] group0_enable_r;          // per-source gate, group zero
    logic [7:0] group1_enable_r;          // per-source gate, group one
    logic [7:0] routing_select_zero_r;    // routed inputs feeding routed zero
    logic [7:0] routing_select_one_r;     // routed inputs feeding routed one
    logic [7:0] routed_input_polarity_r;  // one = active high per input
    logic [1:0] timer_irq_r;              // latched timer interrupts
    logic [1:0] timer_irq_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       group0_irq_r;
    logic       group1_irq_r;

    // synchronised pin copies
    lim_sync_if #(.W(SW)) sif ();

    // pins 5 and 4 of the routed group come from the fixed devices
    logic [7:0] routed_raw;
    assign routed_raw = {routed_in[7:6], serial_irq_n, kbd_mouse_irq_n,
                         routed_in[3:0]};

    // all asynchronous levels enter through the flop chains
    assign sif.raw = {graphics_irq, parallel_irq, mem_dma_done_irq, ethernet_irq,
                      scsi1_irq, scsi0_irq, fifo_full_irq,
                      vert_retrace_irq, video_vsync_irq, ac_fail_irq,
                      periph_dma_done_irq, general_purpose_irq_lines_n,
                      power_button_irq_n, volume_up_irq_n, volume_down_irq_n,
                      routed_raw, periph_bus_err, mem_bus_err, eisa_err};

    lim_sync #(.W(SW)) u_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .sif     (sif)
    );

    // unpack synchronised levels
    logic [6:0] g0_src;      // graphics down to fifo full
    logic [3:0] g1_src;      // retrace, vsync, ac fail, dma done
    logic [1:0] gp_n;        // general purpose lines, active low
    logic [2:0] panel_n;     // power, volume up, volume down
    logic [7:0] routed_lvl;  // routed inputs as seen at the pins
    logic [2:0] err_src;     // bus error sources
    assign g0_src     = sif.sync[26:20];
    assign g1_src     = sif.sync[19:16];
    assign gp_n       = sif.sync[15:14];
    assign panel_n    = sif.sync[13:11];
    assign routed_lvl = sif.sync[10:3];
    assign err_src    = sif.sync[2:0];

    // polarity correction comes first so both masks see active-high inputs
    logic [7:0] routed_act;
    assign routed_act = ~(routed_lvl ^ routed_input_polarity_r);

    // routed interrupts: any selected active input
    logic routed_zero;
    logic routed_one;
    assign routed_zero = |(routed_act & routing_select_zero_r);
    assign routed_one  = |(routed_act & routing_select_one_r);

    // panel bit: any panel line low
    logic panel_act;
    assign panel_act = ~(&panel_n);

    // status bytes, not gated by the enables
    logic [7:0] group0_status;
    logic [7:0] group1_status;
    logic [7:0] routed_status;
    logic [7:0] bus_err_status;
    assign group0_status = {routed_zero, g0_src};
    assign group1_status = {g1_src, routed_one, ~gp_n[1], panel_act,
                            ~gp_n[0]};
    // raw pin levels, independent of masks and polarity
    assign routed_status  = routed_lvl;
    assign bus_err_status = {5'h00, err_src};

    // address decode on the low byte of the full register address
    logic hit_g0_stat;
    logic hit_g0_en;
    logic hit_g1_stat;
    logic hit_g1_en;
    logic hit_rt_stat;
    logic hit_rt_sel0;
    logic hit_rt_sel1;
    logic hit_rt_pol;
    logic hit_tmr_ack;
    logic hit_bus_err;
    assign hit_g0_stat = reg_addr == lim_pkg::LIM_G0_STATUS_ADDR[7:0];
    assign hit_g0_en   = reg_addr == lim_pkg::LIM_G0_ENABLE_ADDR[7:0];
    assign hit_g1_stat = reg_addr == lim_pkg::LIM_G1_STATUS_ADDR[7:0];
    assign hit_g1_en   = reg_addr == lim_pkg::LIM_G1_ENABLE_ADDR[7:0];
    assign hit_rt_stat = reg_addr == lim_pkg::LIM_RT_STATUS_ADDR[7:0];
    assign hit_rt_sel0 = reg_addr == lim_pkg::LIM_RT_SEL0_ADDR[7:0];
    assign hit_rt_sel1 = reg_addr == lim_pkg::LIM_RT_SEL1_ADDR[7:0];
    assign hit_rt_pol  = reg_addr == lim_pkg::LIM_RT_POL_ADDR[7:0];
    assign hit_tmr_ack = reg_addr == lim_pkg::LIM_TMR_ACK_ADDR[7:0];
    assign hit_bus_err = reg_addr == lim_pkg::LIM_BUS_ERR_ADDR[7:0];

    // qualified strobes
    logic wr_en;
    logic rd_en;
    assign wr_en = reg_sel & reg_wr;
    assign rd_en = reg_sel & reg_rd;

    // acknowledge pulse: ones in bits 1 and 0 of the written byte clear the timer latches
    logic [1:0] tmr_clr;
    assign tmr_clr = (wr_en && hit_tmr_ack) ?
                     {reg_wdata[lim_pkg::LIM_TMR1_BIT], reg_wdata[lim_pkg::LIM_TMR0_BIT]}
                     : 2'h0;

    // a timer event in the clearing cycle survives: set beats clear
    assign timer_irq_nxt = (timer_irq_r & ~tmr_clr) | timer_evt;

    // read mux; write-only and unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (1'b1)
            hit_g0_stat: rdata_nxt = group0_status;
            hit_g0_en:   rdata_nxt = group0_enable_r;
            hit_g1_stat: rdata_nxt = group1_status;
            hit_g1_en:   rdata_nxt = group1_enable_r;
            hit_rt_stat: rdata_nxt = routed_status;
            hit_rt_sel0: rdata_nxt = routing_select_zero_r;
            hit_rt_sel1: rdata_nxt = routing_select_one_r;
            hit_rt_pol:  rdata_nxt = routed_input_polarity_r;
            hit_bus_err: rdata_nxt = bus_err_status;
            default:     rdata_nxt = 8'h00;
        endcase
    end

    // enable registers, cleared at reset so no group source reaches the cpu
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            group0_enable_r <= lim_pkg::LIM_ENABLE_RST;
            group1_enable_r <= lim_pkg::LIM_ENABLE_RST;
        end else begin
            if (wr_en && hit_g0_en) begin
                group0_enable_r <= reg_wdata;
            end
            if (wr_en && hit_g1_en) begin
                group1_enable_r <= reg_wdata;
            end
        end
    end

    // routing selects and polarity; software owns bits 5 and 4 of polarity
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            routing_select_zero_r   <= lim_pkg::LIM_RT_SEL_RST;
            routing_select_one_r    <= lim_pkg::LIM_RT_SEL_RST;
            routed_input_polarity_r <= lim_pkg::LIM_RT_POL_RST;
        end else begin
            if (wr_en && hit_rt_sel0) begin
                routing_select_zero_r <= reg_wdata;
            end
            if (wr_en && hit_rt_sel1) begin
                routing_select_one_r <= reg_wdata;
            end
            // no forcing of bits 5 and 4: a wrong write is the host's fault
            if (wr_en && hit_rt_pol) begin
                routed_input_polarity_r <= reg_wdata;
            end
        end
    end

    // timer latches and read data register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_irq_r <= lim_pkg::LIM_TMR_RST;
            rdata_r     <= lim_pkg::LIM_RDATA_RST;
        end else begin
            timer_irq_r <= timer_irq_nxt;
            // read data held until the next read
            if (rd_en) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // group outputs registered to keep them glitch free toward the cpu
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            group0_irq_r <= 1'b0;
            group1_irq_r <= 1'b0;
        end else begin
            group0_irq_r <= |(group0_status & group0_enable_r);
            group1_irq_r <= |(group1_status & group1_enable_r);
        end
    end

    assign reg_rdata  = rdata_r;
    assign group0_irq = group0_irq_r;
    assign group1_irq = group1_irq_r;
    assign timer_irq  = timer_irq_r;

endmodule // lim_top

// File: inc/lim_pkg.sv
// constants shared by the local interrupt multiplexor design
package lim_pkg;

    // register map, full byte addresses of the register window
    localparam logic [31:0] LIM_BASE_ADDR       = 32'h1FBD9800;
    localparam logic [31:0] LIM_G0_STATUS_ADDR  = 32'h1FBD9880;
    localparam logic [31:0] LIM_G0_ENABLE_ADDR  = 32'h1FBD9884;
    localparam logic [31:0] LIM_G1_STATUS_ADDR  = 32'h1FBD9888;
    localparam logic [31:0] LIM_G1_ENABLE_ADDR  = 32'h1FBD988C;
    localparam logic [31:0] LIM_RT_STATUS_ADDR  = 32'h1FBD9890;
    localparam logic [31:0] LIM_RT_SEL0_ADDR    = 32'h1FBD9894;
    localparam logic [31:0] LIM_RT_SEL1_ADDR    = 32'h1FBD9898;
    localparam logic [31:0] LIM_RT_POL_ADDR     = 32'h1FBD989C;
    localparam logic [31:0] LIM_TMR_ACK_ADDR    = 32'h1FBD98A0;
    localparam logic [31:0] LIM_BUS_ERR_ADDR    = 32'h1FBD98A4;

    // width of the byte offset carried on the register port
    localparam int          LIM_OFS_W           = 8;
    localparam int          LIM_DATA_W          = 8;

    // values after reset
    localparam logic [7:0]  LIM_ENABLE_RST      = 8'h00;
    localparam logic [7:0]  LIM_RT_SEL_RST      = 8'h00;
    localparam logic [7:0]  LIM_RT_POL_RST      = 8'h00;
    localparam logic [7:0]  LIM_RDATA_RST       = 8'h00;
    localparam logic [1:0]  LIM_TMR_RST         = 2'h0;

    // bit positions in the group-one status byte
    localparam int          LIM_G1_GP0_BIT      = 0;
    localparam int          LIM_G1_PANEL_BIT    = 1;
    localparam int          LIM_G1_GP2_BIT      = 2;
    localparam int          LIM_G1_ROUTED_BIT   = 3;
    // fixed routed input positions
    localparam int          LIM_RT_DUART_BIT    = 5;
    localparam int          LIM_RT_KBD_BIT      = 4;
    // timer acknowledge bits
    localparam int          LIM_TMR1_BIT        = 1;
    localparam int          LIM_TMR0_BIT        = 0;

    // synchroniser depth, two flops per pin
    localparam int          LIM_SYNC_STAGES     = 2;

endpackage

// File: inc/lim_sync_if.sv
// bundle of raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface lim_sync_if #(
    parameter int W = 27
);
    logic [W-1:0] raw;   // pin levels straight from outside
    logic [W-1:0] sync;  // levels after the flop chain

    modport src  (output raw,  input  sync);
    modport sync_side (input raw, output sync);
endinterface

// File: rtl/lim_sync.sv
// two-flop synchroniser bank for asynchronous interrupt pins
`timescale 1ns/1ps
module lim_sync #(
    parameter int W = 27
) (
    input  wire logic     sys_clk,
    input  wire logic     arst_n,
    lim_sync_if.sync_side sif
);

    // first and second stage; the first is read only by the second
    logic [W-1:0] meta_r;
    logic [W-1:0] hold_r;

    // one chain per bit, built as a loop so width follows the pin count
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r[i] <= 1'b0;
                    hold_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= sif.raw[i];
                    hold_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign sif.sync = hold_r;

endmodule // lim_sync

// File: tb/lim_assertions.sv
// port-level checks for the local interrupt multiplexor
`timescale 1ns/1ps
module lim_assertions (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       reg_sel,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       eisa_err,
    input wire logic [1:0] timer_evt,
    input wire logic       group0_irq,
    input wire logic       group1_irq,
    input wire logic [1:0] timer_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // decoded accesses, named so the properties stay short
    wire logic rd_now  = reg_sel && reg_rd;
    wire logic wr_now  = reg_sel && reg_wr;
    wire logic tmr_wr  = wr_now && reg_addr == 8'hA0;

    rst_quiet_a: assert property (
        $rose(arst_n) |-> !group0_irq && !group1_irq && timer_irq == 2'h0)
        else $error("outputs active right after reset");
    tmr_set_a: assert property (
        timer_evt != 2'h0 |=> (timer_irq & $past(timer_evt)) == $past(timer_evt))
        else $error("timer event did not latch");
    tmr_clr0_a: assert property (
        tmr_wr && reg_wdata[0] && !timer_evt[0] |=> !timer_irq[0])
        else $error("timer zero not cleared");
    tmr_clr1_a: assert property (
        tmr_wr && reg_wdata[1] && !timer_evt[1] |=> !timer_irq[1])
        else $error("timer one not cleared");
    tmr_hold_a: assert property (
        timer_irq[0] && !(tmr_wr && reg_wdata[0]) |=> timer_irq[0])
        else $error("timer zero dropped without clear");
    g0_off_a: assert property (
        wr_now && reg_addr == 8'h84 && reg_wdata == 8'h00 |-> ##2 !group0_irq)
        else $error("group zero output with all sources blocked");
    g1_off_a: assert property (
        wr_now && reg_addr == 8'h8C && reg_wdata == 8'h00 |-> ##2 !group1_irq)
        else $error("group one output with all sources blocked");
    rd_zero_a: assert property (
        rd_now && (reg_addr == 8'hA0 || reg_addr == 8'hA8) |=> reg_rdata == 8'h00)
        else $error("write-only or unmapped read not zero");
    err_unused_a: assert property (
        rd_now && reg_addr == 8'hA4 |=> reg_rdata[7:3] == 5'h00)
        else $error("unused error bits not zero");
    err_pin_a: assert property (
        rd_now && reg_addr == 8'hA4 && $past(eisa_err, 2) && $past(eisa_err, 3)
        |=> reg_rdata[0])
        else $error("error bit missing");
endmodule // lim_assertions

// File: tb/lim_host.sv
// host model driving the register port
`timescale 1ns/1ps
module lim_host (
    input  wire logic       sys_clk,
    output logic            reg_sel,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle port at time zero
    initial begin
        {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h0;
    end
    // one access: raised after a falling edge, taken at the rising edge, read data
    // sampled and strobes dropped at the next falling edge; idle address and data
    // show inverted values so a stale byte never looks current
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge sys_clk);
        {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'h1, w, !w, a, d};
        @(negedge sys_clk);
        q = reg_rdata;
        {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h0, ~a, ~d};
    endtask
endmodule // lim_host

// File: tb/tb.sv
// self-checking bench for the local interrupt multiplexor
`timescale 1ns/1ps
module tb;
    logic       sys_clk = 1'h0, arst_n = 1'h0, reg_sel, reg_wr, reg_rd, group0_irq, group1_irq;
    logic       graphics_irq = 1'h0, parallel_irq = 1'h0, mem_dma_done_irq = 1'h0;
    logic       ethernet_irq = 1'h0, scsi1_irq = 1'h0, scsi0_irq = 1'h0, fifo_full_irq = 1'h0;
    logic       vert_retrace_irq = 1'h0, video_vsync_irq = 1'h0, ac_fail_irq = 1'h0;
    logic       periph_dma_done_irq = 1'h0, periph_bus_err = 1'h0, mem_bus_err = 1'h0;
    logic       eisa_err = 1'h0, serial_irq_n = 1'h1, kbd_mouse_irq_n = 1'h1;
    logic       power_button_irq_n = 1'h1, volume_up_irq_n = 1'h1, volume_down_irq_n = 1'h1;
    logic [1:0] general_purpose_irq_lines_n = 2'h3, timer_evt = 2'h0, timer_irq;
    logic [7:0] routed_in = 8'h00, reg_addr, reg_wdata, reg_rdata;
    logic [7:0] rw_addr [5] = '{8'h84, 8'h8C, 8'h94, 8'h98, 8'h9C}; // writable registers
    int         fail_count = 0, comparisons = 0;

    lim_top u_dut (
        .sys_clk                     (sys_clk),
        .arst_n                      (arst_n),
        .reg_sel                     (reg_sel),
        .reg_wr                      (reg_wr),
        .reg_rd                      (reg_rd),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_rdata                   (reg_rdata),
        .graphics_irq                (graphics_irq),
        .parallel_irq                (parallel_irq),
        .mem_dma_done_irq            (mem_dma_done_irq),
        .ethernet_irq                (ethernet_irq),
        .scsi1_irq                   (scsi1_irq),
        .scsi0_irq                   (scsi0_irq),
        .fifo_full_irq               (fifo_full_irq),
        .vert_retrace_irq            (vert_retrace_irq),
        .video_vsync_irq             (video_vsync_irq),
        .ac_fail_irq                 (ac_fail_irq),
        .periph_dma_done_irq         (periph_dma_done_irq),
        .general_purpose_irq_lines_n (general_purpose_irq_lines_n),
        .power_button_irq_n          (power_button_irq_n),
        .volume_up_irq_n             (volume_up_irq_n),
        .volume_down_irq_n           (volume_down_irq_n),
        .routed_in                   (routed_in),
        .serial_irq_n                (serial_irq_n),
        .kbd_mouse_irq_n             (kbd_mouse_irq_n),
        .periph_bus_err              (periph_bus_err),
        .mem_bus_err                 (mem_bus_err),
        .eisa_err                    (eisa_err),
        .timer_evt                   (timer_evt),
        .group0_irq                  (group0_irq),
        .group1_irq                  (group1_irq),
        .timer_irq                   (timer_irq)
    );
    lim_host u_host (
        .sys_clk   (sys_clk),
        .reg_sel   (reg_sel),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata)
    );

    // free-running clock, 40 ns period
    initial forever #20 sys_clk = ~sys_clk;
    // watchdog, well past the few hundred cycles the sequence needs
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.acc(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.acc(1'h0, a, 8'h00, q);
        chk(q, e);
    endtask
    // pins pass two sync flops plus the output register, so three cycles settle them
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // main sequence, inputs change only at falling edges
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) arst_n = 1'h1;
        foreach (rw_addr[i]) rd(rw_addr[i], 8'h00);
        // pattern keeps polarity bits 5 and 4 low
        foreach (rw_addr[i]) wr(rw_addr[i], 8'hC3 ^ 8'(i));
        foreach (rw_addr[i]) rd(rw_addr[i], 8'hC3 ^ 8'(i));
        foreach (rw_addr[i]) wr(rw_addr[i], 8'h00);
        // status writes must be ignored, holes read zero
        wr(8'h80, 8'hFF);
        wr(8'h90, 8'hFF);
        rd(8'h80, 8'h00);
        rd(8'hA0, 8'h00);
        rd(8'hA8, 8'h00);
        // group zero: status ignores enables, output needs both
        {ethernet_irq, scsi0_irq} = 2'h3;
        wt(3);
        rd(8'h80, 8'h0A);
        chk({7'h0, group0_irq}, 8'h00);
        wr(8'h84, 8'h08);
        wt(3);
        chk({7'h0, group0_irq}, 8'h01);
        wr(8'h84, 8'h00);
        {ethernet_irq, scsi0_irq} = 2'h0;
        // alternating patterns catch swapped group-zero source bits
        {graphics_irq, parallel_irq, mem_dma_done_irq, ethernet_irq} = 4'hA;
        {scsi1_irq, scsi0_irq, fifo_full_irq} = 3'h5;
        wt(3);
        rd(8'h80, 8'h55);
        {graphics_irq, parallel_irq, mem_dma_done_irq, ethernet_irq} = 4'h5;
        {scsi1_irq, scsi0_irq, fifo_full_irq} = 3'h2;
        wt(3);
        rd(8'h80, 8'h2A);
        {graphics_irq, parallel_irq, mem_dma_done_irq, ethernet_irq} = 4'h0;
        {scsi1_irq, scsi0_irq, fifo_full_irq} = 3'h0;
        // group one raw sources and low-active lines
        {vert_retrace_irq, ac_fail_irq} = 2'h3;
        general_purpose_irq_lines_n = 2'h2;
        wt(3);
        rd(8'h88, 8'hA1);
        for (int i = 0; i < 3; i++) begin
            {power_button_irq_n, volume_up_irq_n, volume_down_irq_n} = ~(3'h1 << i);
            wt(3);
            rd(8'h88, 8'hA3);
        end
        {power_button_irq_n, volume_up_irq_n, volume_down_irq_n} = 3'h7;
        general_purpose_irq_lines_n = 2'h1;
        wt(3);
        rd(8'h88, 8'hA4);
        {vert_retrace_irq, ac_fail_irq} = 2'h0;
        general_purpose_irq_lines_n = 2'h3;
        // the other two raw group-one sources
        {vert_retrace_irq, video_vsync_irq, ac_fail_irq, periph_dma_done_irq} = 4'h5;
        wt(3);
        rd(8'h88, 8'h50);
        {vert_retrace_irq, video_vsync_irq, ac_fail_irq, periph_dma_done_irq} = 4'h0;
        // routed inputs: raw status, polarity before masking
        routed_in = 8'hF0;
        serial_irq_n = 1'h0;
        wt(3);
        rd(8'h90, 8'hD0);
        // low routed bits and the keyboard line, then back to the first pattern
        routed_in = 8'h0F;
        {serial_irq_n, kbd_mouse_irq_n} = 2'h2;
        wt(3);
        rd(8'h90, 8'h2F);
        routed_in = 8'hF0;
        {serial_irq_n, kbd_mouse_irq_n} = 2'h1;
        wr(8'h94, 8'h20);
        wt(3);
        rd(8'h80, 8'h80);
        wr(8'h94, 8'hC0);
        wt(3);
        rd(8'h80, 8'h00);
        wr(8'h9C, 8'hC0);
        wt(3);
        rd(8'h80, 8'h80);
        rd(8'h90, 8'hD0);
        wr(8'h98, 8'h08);
        wt(3);
        rd(8'h88, 8'h08);
        wr(8'h8C, 8'h08);
        wt(3);
        chk({7'h0, group1_irq}, 8'h01);
        wr(8'h98, 8'h00);
        wt(3);
        rd(8'h88, 8'h00);
        chk({7'h0, group1_irq}, 8'h00);
        wr(8'h8C, 8'h00);
        // timers latch events until a one is written to their own bit
        timer_evt = 2'h3;
        @(negedge sys_clk) timer_evt = 2'h0;
        chk({6'h0, timer_irq}, 8'h03);
        wr(8'hA0, 8'hFC);
        wt(1);
        chk({6'h0, timer_irq}, 8'h03);
        wr(8'hA0, 8'h01);
        wt(1);
        chk({6'h0, timer_irq}, 8'h02);
        wr(8'hA0, 8'h02);
        wt(1);
        chk({6'h0, timer_irq}, 8'h00);
        // error status is read-only
        {periph_bus_err, mem_bus_err, eisa_err} = 3'h5;
        wt(4);
        rd(8'hA4, 8'h05);
        wr(8'hA4, 8'hFA);
        rd(8'hA4, 8'h05);
        {periph_bus_err, mem_bus_err, eisa_err} = 3'h2;
        wt(3);
        rd(8'hA4, 8'h02);
        // reset in mid-run clears the enables again
        wr(8'h84, 8'hFF);
        arst_n = 1'h0;
        wt(1);
        arst_n = 1'h1;
        rd(8'h84, 8'h00);
        wrap_up();
    end
endmodule // tb

bind lim_top lim_assertions u_chk (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .reg_sel    (reg_sel),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_rdata  (reg_rdata),
    .eisa_err   (eisa_err),
    .timer_evt  (timer_evt),
    .group0_irq (group0_irq),
    .group1_irq (group1_irq),
    .timer_irq  (timer_irq)
);
